/* dpr_map.svh */
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH

// register offsets as printed; each is a word index, byte address is four times it
`define DPR_OFF_CH2_SRC_LO  32'h50003520
`define DPR_OFF_CH2_SRC_HI  32'h50003522
`define DPR_OFF_CH2_DST_LO  32'h50003524
`define DPR_OFF_CH2_DST_HI  32'h50003526
`define DPR_OFF_CH2_THR     32'h50003528
`define DPR_OFF_CH2_LEN     32'h5000352A
`define DPR_OFF_CH2_CTRL    32'h5000352C
`define DPR_OFF_CH2_IDX     32'h5000352E
`define DPR_OFF_CH3_SRC_LO  32'h50003530
`define DPR_OFF_CH3_SRC_HI  32'h50003532
`define DPR_OFF_CH3_DST_LO  32'h50003534
`define DPR_OFF_CH3_DST_HI  32'h50003536
`define DPR_OFF_CH3_THR     32'h50003538
`define DPR_OFF_CH3_LEN     32'h5000353A
`define DPR_OFF_CH3_CTRL    32'h5000353C
`define DPR_OFF_CH3_IDX     32'h5000353E

`define DPR_APB_AW          12

// control word fields
`define DPR_CTRL_ON         0
`define DPR_CTRL_W_LO       1
`define DPR_CTRL_W_HI       2
`define DPR_CTRL_IRQEN      3
`define DPR_CTRL_TRIG       4
`define DPR_CTRL_DINC       5
`define DPR_CTRL_SINC       6
`define DPR_CTRL_CIRC       7
`define DPR_CTRL_PRIO_LO    8
`define DPR_CTRL_PRIO_HI    10
`define DPR_CTRL_IDLE       11
`define DPR_CTRL_FILL       12
`define DPR_CTRL_SENSE      13
`define DPR_CTRL_W          14

`define DPR_RST_16          16'h0000
`define DPR_RST_32          32'h00000000

`endif

/* dpr_pkg.sv */
`include "dpr_map.svh"

package dpr_pkg;

    typedef enum logic [1:0]
    {
        DPR_IDLE  = 2'b00,
        DPR_READ  = 2'b01,
        DPR_WRITE = 2'b11,
        DPR_GAP   = 2'b10
    } dpr_state_e;

    typedef enum logic [2:0]
    {
        DPR_R_SRC_LO = 3'h0,
        DPR_R_SRC_HI = 3'h1,
        DPR_R_DST_LO = 3'h2,
        DPR_R_DST_HI = 3'h3,
        DPR_R_THR    = 3'h4,
        DPR_R_LEN    = 3'h5,
        DPR_R_CTRL   = 3'h6,
        DPR_R_IDX    = 3'h7
    } dpr_reg_e;

    typedef struct packed
    {
        logic                 hit;
        logic                 ch;
        dpr_reg_e             sel;
    } dpr_dec_s;

    typedef struct packed
    {
        logic [31:0]          src_start;
        logic [31:0]          dst_start;
        logic [15:0]          thr;
        logic [15:0]          len;
        logic [`DPR_CTRL_W-1:0] ctrl;
        logic                 active;
        logic [15:0]          idx;
        logic [31:0]          snap_src;
        logic [31:0]          snap_dst;
        logic [15:0]          snap_len;
        logic [`DPR_CTRL_W-1:0] snap_ctrl;
        logic [2:0]           req_s;
        logic                 req_lvl;
        logic                 req_pend;
        logic                 irq;
    } dpr_chan_s;

    typedef struct packed
    {
        dpr_state_e           state;
        logic                 write;
        logic [31:0]          addr;
        logic [31:0]          wdata;
    } dpr_bus_s;

    typedef struct packed
    {
        dpr_chan_s [1:0]      ch;
        dpr_state_e           state;
        logic                 cur;
        logic [31:0]          data;
        logic                 mem_req;
        logic                 mem_write;
        logic [31:0]          mem_addr;
        logic [1:0]           mem_size;
        logic [31:0]          mem_wdata;
        logic                 bus_hold;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } dpr_state_s;

    function automatic logic [`DPR_APB_AW-1:0] dpr_baddr(input logic [31:0] off);
        return {off[`DPR_APB_AW-3:0], 2'b00};
    endfunction : dpr_baddr

    // item address from start, index, increment enable and width
    function automatic logic [31:0] dpr_addr(input logic [31:0] base, input logic [15:0] i,
                                             input logic inc, input logic [1:0] w);
        logic [17:0] off;
        off = 18'h00000;
        if (inc)
        begin
            case (w)
                2'b00:   off = {2'b00, i};
                2'b01:   off = {1'b0, i, 1'b0};
                default: off = {i, 2'b00};
            endcase
        end
        return base + {14'h0000, off};
    endfunction : dpr_addr

    // first bus access of item i; fill mode reads only item 0
    function automatic dpr_bus_s dpr_issue(input dpr_chan_s c, input logic [15:0] i, input logic [31:0] d);
        dpr_bus_s b;
        logic [1:0] w;
        w = c.snap_ctrl[`DPR_CTRL_W_HI:`DPR_CTRL_W_LO];
        b.wdata = d;
        if (c.snap_ctrl[`DPR_CTRL_FILL] && i != 16'h0000)
        begin
            b.state = DPR_WRITE;
            b.write = 1'b1;
            b.addr  = dpr_addr(c.snap_dst, i, c.snap_ctrl[`DPR_CTRL_DINC], w);
        end
        else
        begin
            b.state = DPR_READ;
            b.write = 1'b0;
            b.addr  = dpr_addr(c.snap_src, i, c.snap_ctrl[`DPR_CTRL_SINC], w);
        end
        return b;
    endfunction : dpr_issue

    function automatic dpr_dec_s dpr_decode(input logic [`DPR_APB_AW-1:0] a);
        dpr_dec_s d;
        d.hit = 1'b1;
        d.ch  = 1'b0;
        d.sel = DPR_R_SRC_LO;
        if (a == dpr_baddr(`DPR_OFF_CH2_SRC_LO)) d.sel = DPR_R_SRC_LO;
        else if (a == dpr_baddr(`DPR_OFF_CH2_SRC_HI)) d.sel = DPR_R_SRC_HI;
        else if (a == dpr_baddr(`DPR_OFF_CH2_DST_LO)) d.sel = DPR_R_DST_LO;
        else if (a == dpr_baddr(`DPR_OFF_CH2_DST_HI)) d.sel = DPR_R_DST_HI;
        else if (a == dpr_baddr(`DPR_OFF_CH2_THR)) d.sel = DPR_R_THR;
        else if (a == dpr_baddr(`DPR_OFF_CH2_LEN)) d.sel = DPR_R_LEN;
        else if (a == dpr_baddr(`DPR_OFF_CH2_CTRL)) d.sel = DPR_R_CTRL;
        else if (a == dpr_baddr(`DPR_OFF_CH2_IDX)) d.sel = DPR_R_IDX;
        else
        begin
            d.ch = 1'b1;
            if (a == dpr_baddr(`DPR_OFF_CH3_SRC_LO)) d.sel = DPR_R_SRC_LO;
            else if (a == dpr_baddr(`DPR_OFF_CH3_SRC_HI)) d.sel = DPR_R_SRC_HI;
            else if (a == dpr_baddr(`DPR_OFF_CH3_DST_LO)) d.sel = DPR_R_DST_LO;
            else if (a == dpr_baddr(`DPR_OFF_CH3_DST_HI)) d.sel = DPR_R_DST_HI;
            else if (a == dpr_baddr(`DPR_OFF_CH3_THR)) d.sel = DPR_R_THR;
            else if (a == dpr_baddr(`DPR_OFF_CH3_LEN)) d.sel = DPR_R_LEN;
            else if (a == dpr_baddr(`DPR_OFF_CH3_CTRL)) d.sel = DPR_R_CTRL;
            else if (a == dpr_baddr(`DPR_OFF_CH3_IDX)) d.sel = DPR_R_IDX;
            else d.hit = 1'b0;
        end
        return d;
    endfunction : dpr_decode

endpackage : dpr_pkg

/* dpr_channel_pair.sv */
// Behaviour
// - irq when threshold equals index, before increment
// - interrupt only with interrupt enable set
// - items moved equal length plus one
// - bit 13 selects level or rising-edge requests
// - fill mode reads once, writes every destination
// - fill transfer keeps other channels off bus
// - idle bit 0: back-to-back, bus held throughout; here triggered items return to idle after each store
// - idle bit 1: one wait after store, unless triggered
// - three-bit priority, higher value wins
// - equal priority: lower channel wins
// - normal mode stops and clears enable
// - circular triggered mode restarts, keeps enable
// - source advances 1/2/4 when increment set
// - destination advances by width when increment set
// - trigger bit: start at once or await request
// - width field: byte, half, word, reserved
// - enable runs channel, cleared on completion
// - index counts items, returns to zero
// - addresses from start, index, increments, width
// - start addresses written as two halves
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_channel_pair
    import dpr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`DPR_APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [1:0]             periph_req,
    output logic                        mem_req,
    output logic                        mem_write,
    output logic      [31:0]            mem_addr,
    output logic      [1:0]             mem_size,
    output logic      [31:0]            mem_wdata,
    input  wire logic [31:0]            mem_rdata,
    input  wire logic                   mem_ready,
    output logic                        bus_hold,
    output logic      [1:0]             chan_irq
);

    dpr_state_s s_ff;
    dpr_state_s nxt_s_ff;

    dpr_dec_s   dec;
    dpr_bus_s   iss;
    logic [1:0] elig;
    logic [1:0] rise;
    logic       win;
    logic       lock;
    logic       c;
    logic [15:0] i;
    logic       trig;
    logic       gap_mode;
    logic       last;
    logic [31:0] rd;

    always_comb
    begin
        nxt_s_ff = s_ff;
        dec      = dpr_decode(paddr);
        iss      = '0;
        win      = 1'b0;
        c        = s_ff.cur;
        i        = s_ff.ch[s_ff.cur].idx;
        trig     = s_ff.ch[s_ff.cur].snap_ctrl[`DPR_CTRL_TRIG];
        gap_mode = s_ff.ch[s_ff.cur].snap_ctrl[`DPR_CTRL_IDLE] && !trig;
        last     = (i == s_ff.ch[s_ff.cur].snap_len);
        rd       = 32'h00000000;
        nxt_s_ff.pready  = 1'b0;
        nxt_s_ff.pslverr = 1'b0;

        for (int k = 0; k < 2; k++)
        begin
            nxt_s_ff.ch[k].irq   = 1'b0;
            nxt_s_ff.ch[k].req_s = {s_ff.ch[k].req_s[1:0], periph_req[k]};
            // level accepted once second and third stages agree
            rise[k] = 1'b0;
            if (s_ff.ch[k].req_s[1] == s_ff.ch[k].req_s[2])
            begin
                nxt_s_ff.ch[k].req_lvl = s_ff.ch[k].req_s[2];
                rise[k] = s_ff.ch[k].req_s[2] && !s_ff.ch[k].req_lvl;
            end
            // a request waits on its trigger and sense setting
            if (!s_ff.ch[k].snap_ctrl[`DPR_CTRL_TRIG])
                elig[k] = 1'b1;
            else if (s_ff.ch[k].snap_ctrl[`DPR_CTRL_SENSE])
                elig[k] = s_ff.ch[k].req_pend;
            else
                elig[k] = s_ff.ch[k].req_lvl;
            elig[k] = elig[k] && s_ff.ch[k].active && s_ff.ch[k].ctrl[`DPR_CTRL_ON];
            // start: snapshot addresses, length and control for the transfer; threshold, irq enable and enable bit are read live
            if (s_ff.ch[k].ctrl[`DPR_CTRL_ON] && !s_ff.ch[k].active)
            begin
                nxt_s_ff.ch[k].active    = 1'b1;
                nxt_s_ff.ch[k].idx       = `DPR_RST_16;
                nxt_s_ff.ch[k].snap_src  = s_ff.ch[k].src_start;
                nxt_s_ff.ch[k].snap_dst  = s_ff.ch[k].dst_start;
                nxt_s_ff.ch[k].snap_len  = s_ff.ch[k].len;
                nxt_s_ff.ch[k].snap_ctrl = s_ff.ch[k].ctrl;
                nxt_s_ff.ch[k].req_pend  = 1'b0;
            end
            // software turned the channel off: stop between items
            if (!s_ff.ch[k].ctrl[`DPR_CTRL_ON] && s_ff.ch[k].active &&
                (s_ff.state == DPR_IDLE || s_ff.cur != k[0]))
            begin
                nxt_s_ff.ch[k].active = 1'b0;
                nxt_s_ff.ch[k].idx    = `DPR_RST_16;
            end
        end

        // fill transfer owns the mover until it ends
        lock = s_ff.ch[s_ff.cur].active && s_ff.ch[s_ff.cur].ctrl[`DPR_CTRL_ON] &&
               s_ff.ch[s_ff.cur].snap_ctrl[`DPR_CTRL_FILL];

        case (s_ff.state)
            DPR_IDLE:
            begin
                if (lock)
                    win = s_ff.cur;
                else if (elig[1] && (!elig[0] ||
                         s_ff.ch[1].snap_ctrl[`DPR_CTRL_PRIO_HI:`DPR_CTRL_PRIO_LO] >
                         s_ff.ch[0].snap_ctrl[`DPR_CTRL_PRIO_HI:`DPR_CTRL_PRIO_LO]))
                    win = 1'b1;
                else
                    win = 1'b0;
                if (elig[win])
                begin
                    iss = dpr_issue(s_ff.ch[win], s_ff.ch[win].idx, s_ff.data);
                    nxt_s_ff.cur       = win;
                    nxt_s_ff.state     = iss.state;
                    nxt_s_ff.mem_req   = 1'b1;
                    nxt_s_ff.mem_write = iss.write;
                    nxt_s_ff.mem_addr  = iss.addr;
                    nxt_s_ff.mem_wdata = iss.wdata;
                    nxt_s_ff.mem_size  = s_ff.ch[win].snap_ctrl[`DPR_CTRL_W_HI:`DPR_CTRL_W_LO];
                    if (s_ff.ch[win].snap_ctrl[`DPR_CTRL_SENSE])
                        nxt_s_ff.ch[win].req_pend = 1'b0;
                end
            end
            DPR_READ:
            begin
                if (mem_ready)
                begin
                    nxt_s_ff.data      = mem_rdata;
                    nxt_s_ff.state     = DPR_WRITE;
                    nxt_s_ff.mem_write = 1'b1;
                    nxt_s_ff.mem_wdata = mem_rdata;
                    nxt_s_ff.mem_addr  = dpr_addr(s_ff.ch[c].snap_dst, i, s_ff.ch[c].snap_ctrl[`DPR_CTRL_DINC],
                                                  s_ff.ch[c].snap_ctrl[`DPR_CTRL_W_HI:`DPR_CTRL_W_LO]);
                end
            end
            DPR_WRITE:
            begin
                if (mem_ready)
                begin
                    nxt_s_ff.mem_req   = 1'b0;
                    nxt_s_ff.mem_write = 1'b0;
                    nxt_s_ff.state     = gap_mode ? DPR_GAP : DPR_IDLE;
                    if (s_ff.ch[c].ctrl[`DPR_CTRL_IRQEN] && s_ff.ch[c].thr == i)
                        nxt_s_ff.ch[c].irq = 1'b1;
                    if (last)
                    begin
                        nxt_s_ff.ch[c].idx = `DPR_RST_16;
                        if (s_ff.ch[c].snap_ctrl[`DPR_CTRL_CIRC] && trig)
                        begin
                            nxt_s_ff.ch[c].snap_src  = s_ff.ch[c].src_start;
                            nxt_s_ff.ch[c].snap_dst  = s_ff.ch[c].dst_start;
                            nxt_s_ff.ch[c].snap_len  = s_ff.ch[c].len;
                            nxt_s_ff.ch[c].snap_ctrl = s_ff.ch[c].ctrl;
                        end
                        else
                        begin
                            nxt_s_ff.ch[c].active           = 1'b0;
                            nxt_s_ff.ch[c].ctrl[`DPR_CTRL_ON] = 1'b0;
                        end
                    end
                    else
                    begin
                        nxt_s_ff.ch[c].idx = i + 16'h0001;
                        // blocking mode chains the next item with no idle cycle
                        if (!trig && !gap_mode && s_ff.ch[c].ctrl[`DPR_CTRL_ON])
                        begin
                            iss = dpr_issue(s_ff.ch[c], i + 16'h0001, s_ff.data);
                            nxt_s_ff.state     = iss.state;
                            nxt_s_ff.mem_req   = 1'b1;
                            nxt_s_ff.mem_write = iss.write;
                            nxt_s_ff.mem_addr  = iss.addr;
                            nxt_s_ff.mem_wdata = iss.wdata;
                        end
                    end
                end
            end
            default:
            begin
                nxt_s_ff.state = DPR_IDLE;
            end
        endcase

        // edge requests: a new edge beats the consume in the same cycle
        for (int k = 0; k < 2; k++)
        begin
            if (rise[k] && s_ff.ch[k].snap_ctrl[`DPR_CTRL_SENSE])
                nxt_s_ff.ch[k].req_pend = 1'b1;
        end

        nxt_s_ff.bus_hold = (nxt_s_ff.state == DPR_READ) || (nxt_s_ff.state == DPR_WRITE);

        // apb: setup cycle latches the answer, access phase applies writes
        case (dec.sel)
            DPR_R_SRC_LO: rd = {16'h0000, s_ff.ch[dec.ch].src_start[15:0]};
            DPR_R_SRC_HI: rd = {16'h0000, s_ff.ch[dec.ch].src_start[31:16]};
            DPR_R_DST_LO: rd = {16'h0000, s_ff.ch[dec.ch].dst_start[15:0]};
            DPR_R_DST_HI: rd = {16'h0000, s_ff.ch[dec.ch].dst_start[31:16]};
            DPR_R_THR:    rd = {16'h0000, s_ff.ch[dec.ch].thr};
            DPR_R_LEN:    rd = {16'h0000, s_ff.ch[dec.ch].len};
            DPR_R_CTRL:   rd = {18'h00000, s_ff.ch[dec.ch].ctrl};
            default:      rd = {16'h0000, s_ff.ch[dec.ch].idx};
        endcase
        if (psel && !penable)
        begin
            nxt_s_ff.pready  = 1'b1;
            nxt_s_ff.pslverr = !dec.hit;
            nxt_s_ff.prdata  = (dec.hit && !pwrite) ? rd : 32'h00000000;
        end
        else if (psel && penable && s_ff.pready && pwrite && dec.hit)
        begin
            case (dec.sel)
                DPR_R_SRC_LO: nxt_s_ff.ch[dec.ch].src_start[15:0]  = pwdata[15:0];
                DPR_R_SRC_HI: nxt_s_ff.ch[dec.ch].src_start[31:16] = pwdata[15:0];
                DPR_R_DST_LO: nxt_s_ff.ch[dec.ch].dst_start[15:0]  = pwdata[15:0];
                DPR_R_DST_HI: nxt_s_ff.ch[dec.ch].dst_start[31:16] = pwdata[15:0];
                DPR_R_THR:    nxt_s_ff.ch[dec.ch].thr  = pwdata[15:0];
                DPR_R_LEN:    nxt_s_ff.ch[dec.ch].len  = pwdata[15:0];
                DPR_R_CTRL:   nxt_s_ff.ch[dec.ch].ctrl = pwdata[`DPR_CTRL_W-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_ff <= '0;
        else
            s_ff <= nxt_s_ff;
    end

    assign prdata    = s_ff.prdata;
    assign pready    = s_ff.pready;
    assign pslverr   = s_ff.pslverr;
    assign mem_req   = s_ff.mem_req;
    assign mem_write = s_ff.mem_write;
    assign mem_addr  = s_ff.mem_addr;
    assign mem_size  = s_ff.mem_size;
    assign mem_wdata = s_ff.mem_wdata;
    assign bus_hold  = s_ff.bus_hold;
    assign chan_irq  = {s_ff.ch[1].irq, s_ff.ch[0].irq};

endmodule : dpr_channel_pair
`default_nettype wire

/* dpr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_properties (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`DPR_APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [31:0]            prdata,
    input  wire logic                   pready,
    input  wire logic                   pslverr,
    input  wire logic [1:0]             periph_req,
    input  wire logic                   mem_req,
    input  wire logic                   mem_write,
    input  wire logic [31:0]            mem_addr,
    input  wire logic [1:0]             mem_size,
    input  wire logic [31:0]            mem_wdata,
    input  wire logic [31:0]            mem_rdata,
    input  wire logic                   mem_ready,
    input  wire logic                   bus_hold,
    input  wire logic [1:0]             chan_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_ready_timing_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    apb_ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    apb_err_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    mem_hold_stable_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr)
        && $stable(mem_write) && $stable(mem_size)) else $error("memory request changed before ready");
    read_then_write_a: assert property (mem_req && !mem_write && mem_ready |=> mem_req && mem_write)
        else $error("read not followed by store");
    store_copy_data_a: assert property (mem_req && !mem_write && mem_ready |=> mem_wdata == $past(mem_rdata))
        else $error("stored data differs from fetched");
    irq_pulse_once_a: assert property (|chan_irq |=> chan_irq == 2'h0)
        else $error("interrupt longer than one cycle");
    irq_after_store_a: assert property (|chan_irq |-> $past(mem_req && mem_write && mem_ready))
        else $error("interrupt without completed store");
    bus_lock_held_a: assert property (mem_req |-> bus_hold)
        else $error("bus not held during access");
endmodule : dpr_properties

bind dpr_channel_pair dpr_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .bus_hold(bus_hold), .chan_irq(chan_irq));
`default_nettype wire

/* dpr_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dpr_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [1:0]  wait_n,
    output logic      [31:0] mem_rdata,
    output logic             mem_ready
);
    logic [31:0] wa[$], wd[$], ra[$];
    logic [1:0]  cnt_ff;

    // answers after wait_n extra cycles; read data toggles outside the ready cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff    <= 2'h0;
            mem_ready <= 1'b0;
            mem_rdata <= 32'hFFFFFFFF;
        end
        else
        begin
            if (mem_req && mem_ready && mem_write)
            begin
                wa.push_back(mem_addr);
                wd.push_back(mem_wdata);
            end
            if (mem_req && mem_ready && !mem_write)
                ra.push_back(mem_addr);
            if (mem_req && !mem_ready && cnt_ff >= wait_n)
            begin
                mem_ready <= 1'b1;
                mem_rdata <= {mem_addr[15:0], ~mem_addr[15:0]};
                cnt_ff    <= 2'h0;
            end
            else
            begin
                mem_ready <= 1'b0;
                mem_rdata <= ~mem_rdata;
                if (mem_req && !mem_ready)
                    cnt_ff <= cnt_ff + 2'h1;
            end
        end
    end
endmodule : dpr_mem_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, b;
    logic [31:0] pwdata = 32'h00000000, prdata, mem_rdata, mem_addr, mem_wdata, r, src, dst;
    logic        pready, pslverr, mem_req, mem_write, mem_ready, bus_hold, e, fill, ch;
    logic [1:0]  periph_req = 2'h0, mem_size, chan_irq, w, wait_n = 2'h0;
    logic [15:0] len, thr, ctl;
    int          miscompares = 0, checks = 0, irqn[2] = '{0, 0}, k, n, n0, r0, i0, t;
    integer      seed = 32'hce8f;

    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        irqn[0] <= irqn[0] + int'(chan_irq[0] === 1'b1);
        irqn[1] <= irqn[1] + int'(chan_irq[1] === 1'b1);
    end

    dpr_channel_pair u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .bus_hold(bus_hold), .chan_irq(chan_irq));
    dpr_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_n(wait_n), .mem_rdata(mem_rdata),
        .mem_ready(mem_ready));

    task automatic conclude;
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            chk(32'h0, 32'h1);
            conclude();
        end
    endtask : apb

    function automatic logic [31:0] ea(input logic [31:0] s, input int i, input logic inc, input logic [1:0] bw);
        return inc ? s + (32'(i) << bw) : s;
    endfunction : ea

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            apb(1'b0, 12'h480 + 12'(k * 8), 32'h0);
            chk(r, 32'h0);
            chk({31'h0, e}, 32'h0);
        end
        apb(1'b0, 12'h400, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (k = 0; k < 16; k++)
        begin
            src = $random(seed);
            apb(1'b1, 12'h480 + 12'(k * 8), k % 8 == 6 ? src & 32'hFFFFFFFE : src);
            apb(1'b0, 12'h480 + 12'(k * 8), 32'h0);
            chk(r, k % 8 == 7 ? 32'h0 : k % 8 == 6 ? src & 32'h3FFE : src & 32'hFFFE | 32'(src[0] & k % 8 != 6));
        end
        for (n = 0; n < 14; n++)
        begin
            ch = n[0];
            b = ch ? 12'h4C0 : 12'h480;
            src = $random(seed);
            dst = $random(seed);
            len = n == 0 ? 16'h0 : 16'($random(seed) & 7);
            thr = 16'($random(seed) & 7);
            w = 2'({$random(seed)} % 3);
            fill = n % 4 == 3;
            ctl = (16'($random(seed)) & 16'h0F68) | {3'h0, fill, 6'h0, fill, 2'h0, w, 1'b1};
            wait_n <= 2'($random(seed));
            n0 = u_mem.wa.size();
            r0 = u_mem.ra.size();
            i0 = irqn[ch];
            apb(1'b1, b, {16'h0, src[15:0]});
            apb(1'b1, b + 12'h008, {16'h0, src[31:16]});
            apb(1'b1, b + 12'h010, {16'h0, dst[15:0]});
            apb(1'b1, b + 12'h018, {16'h0, dst[31:16]});
            apb(1'b1, b + 12'h020, {16'h0, thr});
            apb(1'b1, b + 12'h028, {16'h0, len});
            apb(1'b1, b + 12'h030, {16'h0, ctl});
            t = 0;
            do
            begin
                apb(1'b0, b + 12'h030, 32'h0);
                t++;
            end
            while (r[0] !== 1'b0 && t < 300);
            repeat (4) @(posedge pclk);
            chk(r, {16'h0, ctl & 16'hFFFE});
            chk({30'h0, mem_size}, {30'h0, w});
            chk(u_mem.wa.size() - n0, 32'(len) + 1);
            chk(u_mem.ra.size() - r0, fill ? 1 : 32'(len) + 1);
            for (k = 0; k <= int'(len) && k < u_mem.wa.size() - n0; k++)
            begin
                chk(u_mem.wa[n0 + k], ea(dst, k, ctl[5], w));
                src = fill ? src : ea(src, k, ctl[6], w);
                chk(u_mem.wd[n0 + k], {src[15:0], ~src[15:0]});
                if (!fill)
                    chk(u_mem.ra[r0 + k], src);
                src = fill ? src : ea(src, -k, ctl[6], w);
            end
            chk(irqn[ch] - i0, 32'(ctl[3] && thr <= len));
            apb(1'b0, b + 12'h038, 32'h0);
            chk(r, 32'h0);
        end
        for (n = 0; n < 2; n++)
        begin
            b = n[0] ? 12'h4C0 : 12'h480;
            n0 = u_mem.wa.size();
            apb(1'b1, b + 12'h028, 32'h1);
            apb(1'b1, b + 12'h030, n ? 32'h20F1 : 32'h00F1);
            repeat (30) @(posedge pclk);
            chk(u_mem.wa.size() - n0, 32'h0);
            periph_req[n] <= 1'b1;
            repeat (80) @(posedge pclk);
            periph_req[n] <= 1'b0;
            repeat (30) @(posedge pclk);
            chk(n ? u_mem.wa.size() - n0 : 32'(u_mem.wa.size() - n0 > 3), 32'h1);
            apb(1'b0, b + 12'h030, 32'h0);
            chk(r, n ? 32'h20F1 : 32'h00F1);
            apb(1'b1, b + 12'h030, 32'h0);
            repeat (30) @(posedge pclk);
        end
        conclude();
    end
endmodule : tb_top
`default_nettype wire
